//--- verilog/swu_pkg.sv
// shared constants and crc for the single wire uart link
package swu_pkg;
  localparam logic [7:0] SYNC_BYTE = 8'h05;
  localparam logic [7:0] NODE_ADDR = 8'h00;
  localparam logic [7:0] HOST_ADDR = 8'hff;
  localparam logic [7:0] CRC_POLY = 8'h07;
  localparam logic [7:0] SYNC_PRESET = 8'ha0;
  localparam int REQ_LAST = 3;
  localparam int WR_LAST = 7;
  localparam int GAP_BITS = 63;
  localparam int RECOVER_BITS = 12;
  localparam int GLITCH_CLKS = 16;
  localparam int TAIL_BITS = 4;
  localparam int TURN_STEP_BITS = 8;
  localparam logic [3:0] TURN_SETTING_DEFAULT = 4'h1;
  localparam int HOST_IDLE_BITS = 2;
  localparam int REPLY_WAIT_BITS = 160;
  localparam int CLK_HZ = 20_000_000;
  localparam int MIN_BAUD = 9000;
  localparam int BIT_CLKS_MAX = CLK_HZ / MIN_BAUD;
  localparam int SYNC_LIMIT_CLKS = 5 * BIT_CLKS_MAX;
  localparam int BT_W = 12;
  localparam int CNT_W = 20;
  localparam logic [BT_W-1:0] BIT_CLKS_RESET = 12'h0a0;
  localparam int HOST_BIT_CLKS = 160;

  function automatic logic [7:0] crcByte(input logic [7:0] crc,
                                         input logic [7:0] b);
    logic [7:0] c;
    c = crc;
    for (int i = 0; i < 8; i++) begin
      if (c[7] ^ b[i]) begin
        c = {c[6:0], 1'b0} ^ CRC_POLY;
      end else begin
        c = {c[6:0], 1'b0};
      end
    end
    return c;
  endfunction
endpackage

//--- verilog/swu_link_if.sv
// shared single wire line between the node and the host
`timescale 1ns/1ps
interface swu_link_if;
  logic devOut;
  logic devOe;
  logic hostOut;
  logic hostOe;
  logic line;
  // pulled up: only an enabled low driver pulls the wire down
  assign line = !((devOe && !devOut) || (hostOe && !hostOut));
  modport device(input line, output devOut, output devOe);
  modport host(input line, output hostOut, output hostOe);
endinterface

//--- verilog/swu_device.sv
// node end: datagram receiver, crc check and delayed read reply
`timescale 1ns/1ps
module swu_device #(
  parameter logic [7:0] NODE_ADDRESS = swu_pkg::NODE_ADDR
) (
  input wire logic core_clk,
  input wire logic rstn,
  swu_link_if.device link,
  input wire logic [3:0] turnSetting,
  input wire logic [31:0] rdData,
  output logic rdReq,
  output logic [6:0] rdAddr,
  output logic wrValid,
  output logic [6:0] wrAddr,
  output logic [31:0] wrData,
  output logic [7:0] dgCount
);
  localparam int CW = swu_pkg::CNT_W;
  localparam int BW = swu_pkg::BT_W;

  typedef enum logic [3:0] {
    D_IDLE = 4'h0,
    D_SYNC = 4'h1,
    D_BITS = 4'h2,
    D_GAP = 4'h3,
    D_RECOVER = 4'h4,
    D_FETCH = 4'h5,
    D_TURN = 4'h6,
    D_SEND = 4'h7,
    D_TAIL = 4'h8
  } swu_dstate_t;

  function automatic logic [CW-1:0] mulBits(input int n,
                                            input logic [BW-1:0] bt);
    return CW'(n) * CW'(bt);
  endfunction

  function automatic logic [7:0] replyByte(input logic [2:0] idx,
                                           input logic [6:0] addr,
                                           input logic [31:0] data,
                                           input logic [7:0] crc);
    logic [7:0] b;
    b = crc;
    unique case (idx)
      3'h0: b = swu_pkg::SYNC_BYTE;
      3'h1: b = swu_pkg::HOST_ADDR;
      3'h2: b = {1'b0, addr};
      3'h3: b = data[31:24];
      3'h4: b = data[23:16];
      3'h5: b = data[15:8];
      3'h6: b = data[7:0];
      3'h7: b = crc;
    endcase
    return b;
  endfunction

  swu_dstate_t state_q;
  logic lineP_q;
  logic fallSeen_q;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] gapCnt_q;
  logic [BW-1:0] bt_q;
  logic [BW-1:0] lastBt_q;
  logic [3:0] bitIdx_q;
  logic [2:0] byteIdx_q;
  logic [7:0] bitsLeft_q;
  logic [7:0] shift_q;
  logic [7:0] crc_q;
  logic addrOk_q;
  logic isWrite_q;
  logic [6:0] rxAddr_q;
  logic [31:0] wrBuf_q;
  logic [31:0] txData_q;
  logic devOut_q;
  logic devOe_q;
  logic rdReq_q;
  logic [6:0] rdAddr_q;
  logic wrValid_q;
  logic [6:0] wrAddr_q;
  logic [31:0] wrData_q;
  logic [7:0] dgCount_q;

  logic fall;
  logic frameEnd;
  logic lastByte;
  logic crcOk;
  logic acceptRead;
  logic acceptWrite;
  logic [7:0] curByte;
  logic [3:0] turnEff;
  logic [CW-1:0] btLoad;

  assign fall = lineP_q && !link.line;
  assign frameEnd = state_q == D_BITS && cnt_q == '0 && bitIdx_q == 4'h8;
  assign lastByte = isWrite_q ? byteIdx_q == 3'(swu_pkg::WR_LAST)
                              : byteIdx_q == 3'(swu_pkg::REQ_LAST);
  assign crcOk = shift_q == crc_q;
  assign acceptRead = frameEnd && link.line && lastByte && !isWrite_q &&
                      crcOk && addrOk_q;
  assign acceptWrite = frameEnd && link.line && lastByte && isWrite_q &&
                       crcOk && addrOk_q;
  assign curByte = replyByte(byteIdx_q, rxAddr_q, txData_q, crc_q);
  assign turnEff = turnSetting == 4'h0 ? 4'h1 : turnSetting;
  assign btLoad = CW'(bt_q) - CW'(1);

  // link sequencing: receive, recovery, turnaround and reply
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= D_IDLE;
      lineP_q <= 1'b1;
      fallSeen_q <= 1'b0;
      cnt_q <= '0;
      gapCnt_q <= '0;
      bt_q <= swu_pkg::BIT_CLKS_RESET;
      lastBt_q <= swu_pkg::BIT_CLKS_RESET;
      bitIdx_q <= 4'h0;
      byteIdx_q <= 3'h0;
      bitsLeft_q <= 8'h00;
      shift_q <= 8'h00;
      crc_q <= 8'h00;
      addrOk_q <= 1'b0;
      isWrite_q <= 1'b0;
      rxAddr_q <= 7'h00;
      wrBuf_q <= 32'h0000_0000;
      txData_q <= 32'h0000_0000;
      devOut_q <= 1'b1;
      devOe_q <= 1'b0;
    end else begin
      lineP_q <= link.line;
      if (gapCnt_q != '1) begin
        gapCnt_q <= gapCnt_q + CW'(1);
      end
      unique case (state_q)
        D_IDLE: begin
          if (fall) begin
            state_q <= D_SYNC;
            cnt_q <= '0;
            gapCnt_q <= '0;
            fallSeen_q <= 1'b0;
            byteIdx_q <= 3'h0;
            crc_q <= 8'h00;
            isWrite_q <= 1'b0;
            addrOk_q <= 1'b0;
          end
        end
        D_SYNC: begin
          cnt_q <= cnt_q + CW'(1);
          if (link.line && !lineP_q &&
              cnt_q < CW'(swu_pkg::GLITCH_CLKS)) begin
            state_q <= D_RECOVER;
            cnt_q <= '0;
          end else if (cnt_q == CW'(swu_pkg::SYNC_LIMIT_CLKS)) begin
            state_q <= D_RECOVER;
            cnt_q <= '0;
          end else if (fall && !fallSeen_q) begin
            fallSeen_q <= 1'b1;
          end else if (fall) begin
            // four bit times elapsed: start, sync bits 0..2
            bt_q <= BW'((cnt_q + CW'(1)) >> 2);
            cnt_q <= ((cnt_q + CW'(1)) >> 3) - CW'(1);
            shift_q <= swu_pkg::SYNC_PRESET;
            bitIdx_q <= 4'h3;
            state_q <= D_BITS;
          end
        end
        D_BITS: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end else if (bitIdx_q < 4'h8) begin
            shift_q <= {link.line, shift_q[7:1]};
            bitIdx_q <= bitIdx_q + 4'h1;
            cnt_q <= btLoad;
          end else if (!link.line) begin
            state_q <= D_RECOVER;
            cnt_q <= '0;
          end else begin
            crc_q <= swu_pkg::crcByte(crc_q, shift_q);
            state_q <= D_GAP;
            if (byteIdx_q == 3'h1) begin
              addrOk_q <= shift_q == NODE_ADDRESS &&
                          shift_q != swu_pkg::HOST_ADDR;
            end
            if (byteIdx_q == 3'h2) begin
              isWrite_q <= shift_q[7];
              rxAddr_q <= shift_q[6:0];
            end
            if (byteIdx_q >= 3'h3 && !lastByte) begin
              wrBuf_q <= {wrBuf_q[23:0], shift_q};
            end
            if (lastByte && !crcOk) begin
              state_q <= D_RECOVER;
              cnt_q <= '0;
            end else if (lastByte) begin
              lastBt_q <= bt_q;
              state_q <= acceptRead ? D_FETCH : D_IDLE;
            end
          end
        end
        D_GAP: begin
          if (gapCnt_q > mulBits(swu_pkg::GAP_BITS, lastBt_q)) begin
            state_q <= D_RECOVER;
            cnt_q <= '0;
          end else if (fall) begin
            gapCnt_q <= '0;
            cnt_q <= btLoad + CW'(bt_q[BW-1:1]);
            bitIdx_q <= 4'h0;
            byteIdx_q <= byteIdx_q + 3'h1;
            state_q <= D_BITS;
          end
        end
        D_RECOVER: begin
          // a low level restarts the quiet period
          if (!link.line) begin
            cnt_q <= '0;
          end else if (cnt_q >=
                       mulBits(swu_pkg::RECOVER_BITS, lastBt_q)) begin
            state_q <= D_IDLE;
          end else begin
            cnt_q <= cnt_q + CW'(1);
          end
        end
        D_FETCH: begin
          txData_q <= rdData;
          cnt_q <= btLoad;
          bitsLeft_q <= 8'(turnEff * swu_pkg::TURN_STEP_BITS);
          state_q <= D_TURN;
        end
        D_TURN: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end else if (bitsLeft_q == 8'h01) begin
            devOe_q <= 1'b1;
            devOut_q <= 1'b0;
            bitIdx_q <= 4'h0;
            byteIdx_q <= 3'h0;
            crc_q <= 8'h00;
            cnt_q <= btLoad;
            state_q <= D_SEND;
          end else begin
            bitsLeft_q <= bitsLeft_q - 8'h01;
            cnt_q <= btLoad;
          end
        end
        D_SEND: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end else begin
            cnt_q <= btLoad;
            if (bitIdx_q == 4'h9) begin
              crc_q <= swu_pkg::crcByte(crc_q, curByte);
              devOut_q <= byteIdx_q == 3'h7;
              if (byteIdx_q == 3'h7) begin
                bitsLeft_q <= 8'(swu_pkg::TAIL_BITS);
                state_q <= D_TAIL;
              end else begin
                byteIdx_q <= byteIdx_q + 3'h1;
                bitIdx_q <= 4'h0;
              end
            end else begin
              devOut_q <= bitIdx_q == 4'h8 ? 1'b1 : curByte[bitIdx_q[2:0]];
              bitIdx_q <= bitIdx_q + 4'h1;
            end
          end
        end
        D_TAIL: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end else if (bitsLeft_q == 8'h01) begin
            devOe_q <= 1'b0;
            state_q <= D_IDLE;
          end else begin
            bitsLeft_q <= bitsLeft_q - 8'h01;
            cnt_q <= btLoad;
          end
        end
        default: begin
          state_q <= D_IDLE;
          devOe_q <= 1'b0;
          devOut_q <= 1'b1;
        end
      endcase
    end
  end

  // user side: register bank requests and the write acknowledge count
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rdReq_q <= 1'b0;
      rdAddr_q <= 7'h00;
      wrValid_q <= 1'b0;
      wrAddr_q <= 7'h00;
      wrData_q <= 32'h0000_0000;
      dgCount_q <= 8'h00;
    end else begin
      rdReq_q <= acceptRead;
      wrValid_q <= acceptWrite;
      if (acceptRead) begin
        rdAddr_q <= rxAddr_q;
      end
      if (acceptWrite) begin
        wrAddr_q <= rxAddr_q;
        wrData_q <= wrBuf_q;
        dgCount_q <= dgCount_q + 8'h01;
      end
    end
  end

  assign link.devOut = devOut_q;
  assign link.devOe = devOe_q;
  assign rdReq = rdReq_q;
  assign rdAddr = rdAddr_q;
  assign wrValid = wrValid_q;
  assign wrAddr = wrAddr_q;
  assign wrData = wrData_q;
  assign dgCount = dgCount_q;
endmodule

//--- verilog/swu_host.sv
// host end: command buffer, datagram sender and reply receiver
`timescale 1ns/1ps
module swu_host #(
  parameter int BIT_CLKS = swu_pkg::HOST_BIT_CLKS,
  parameter int DEPTH = 2
) (
  input wire logic core_clk,
  input wire logic rstn,
  swu_link_if.host link,
  input wire logic cmdValid,
  output logic cmdReady,
  input wire logic cmdWrite,
  input wire logic [6:0] cmdAddr,
  input wire logic [31:0] cmdData,
  output logic rspValid,
  output logic rspOk,
  output logic [31:0] rspData
);
  localparam int CW = swu_pkg::CNT_W;
  localparam int PW = DEPTH > 1 ? $clog2(DEPTH) : 1;
  localparam int LW = $clog2(DEPTH + 1);
  localparam logic [CW-1:0] BIT_LOAD = CW'(BIT_CLKS - 1);

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_SEND = 3'h1,
    H_GAP = 3'h2,
    H_WAIT = 3'h3,
    H_RECV = 3'h4
  } swu_hstate_t;

  function automatic logic [7:0] hostByte(input logic [2:0] idx,
                                          input logic [39:0] cmd,
                                          input logic [7:0] crc);
    logic [7:0] b;
    b = crc;
    unique case (idx)
      3'h0: b = swu_pkg::SYNC_BYTE;
      3'h1: b = swu_pkg::NODE_ADDR;
      3'h2: b = cmd[39:32];
      3'h3: b = cmd[39] ? cmd[31:24] : crc;
      3'h4: b = cmd[23:16];
      3'h5: b = cmd[15:8];
      3'h6: b = cmd[7:0];
      3'h7: b = crc;
    endcase
    return b;
  endfunction

  logic [39:0] mem_q [DEPTH];
  logic [PW-1:0] wp_q;
  logic [PW-1:0] rp_q;
  logic [LW-1:0] level_q;
  logic cmdReady_q;
  swu_hstate_t state_q;
  logic [39:0] cur_q;
  logic [CW-1:0] cnt_q;
  logic [3:0] bitIdx_q;
  logic [2:0] byteIdx_q;
  logic [7:0] crc_q;
  logic [7:0] shift_q;
  logic [31:0] buf_q;
  logic ok_q;
  logic lineP_q;
  logic hostOut_q;
  logic hostOe_q;
  logic rspValid_q;
  logic rspOk_q;
  logic [31:0] rspData_q;

  logic push;
  logic pop;
  logic [LW-1:0] levelD;
  logic [7:0] curByte;
  logic lastTx;
  logic byteOk;

  assign push = cmdValid && cmdReady_q;
  assign pop = state_q == H_IDLE && level_q != '0;
  assign levelD = level_q + LW'(push) - LW'(pop);
  assign curByte = hostByte(byteIdx_q, cur_q, crc_q);
  assign lastTx = cur_q[39] ? byteIdx_q == 3'(swu_pkg::WR_LAST)
                            : byteIdx_q == 3'(swu_pkg::REQ_LAST);
  assign byteOk = link.line &&
                  (byteIdx_q != 3'h0 ||
                   shift_q == swu_pkg::SYNC_BYTE) &&
                  (byteIdx_q != 3'h1 || shift_q == swu_pkg::HOST_ADDR) &&
                  (byteIdx_q != 3'h7 || shift_q == crc_q);

  // two-entry command buffer; the sender drains it only when idle
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wp_q <= '0;
      rp_q <= '0;
      level_q <= '0;
      cmdReady_q <= 1'b0;
    end else begin
      level_q <= levelD;
      cmdReady_q <= levelD < LW'(DEPTH);
      if (push) begin
        wp_q <= wp_q == PW'(DEPTH - 1) ? '0 : wp_q + PW'(1);
      end
      if (pop) begin
        rp_q <= rp_q == PW'(DEPTH - 1) ? '0 : rp_q + PW'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (push) begin
      mem_q[wp_q] <= {cmdWrite, cmdAddr, cmdData};
    end
  end

  // link sequencing
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= H_IDLE;
      cur_q <= '0;
      cnt_q <= '0;
      bitIdx_q <= 4'h0;
      byteIdx_q <= 3'h0;
      crc_q <= 8'h00;
      shift_q <= 8'h00;
      buf_q <= 32'h0000_0000;
      ok_q <= 1'b0;
      lineP_q <= 1'b1;
      hostOut_q <= 1'b1;
      hostOe_q <= 1'b0;
      rspValid_q <= 1'b0;
      rspOk_q <= 1'b0;
      rspData_q <= 32'h0000_0000;
    end else begin
      lineP_q <= link.line;
      rspValid_q <= 1'b0;
      unique case (state_q)
        H_IDLE: begin
          if (pop) begin
            cur_q <= mem_q[rp_q];
            hostOe_q <= 1'b1;
            hostOut_q <= 1'b0;
            bitIdx_q <= 4'h0;
            byteIdx_q <= 3'h0;
            crc_q <= 8'h00;
            cnt_q <= BIT_LOAD;
            state_q <= H_SEND;
          end
        end
        H_SEND: begin
          // own bytes come back on the line and are not looked at
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end else begin
            cnt_q <= BIT_LOAD;
            if (bitIdx_q == 4'h9) begin
              crc_q <= swu_pkg::crcByte(crc_q, curByte);
              bitIdx_q <= 4'h0;
              byteIdx_q <= byteIdx_q + 3'h1;
              hostOut_q <= lastTx;
              if (lastTx) begin
                hostOe_q <= 1'b0;
                byteIdx_q <= 3'h0;
                crc_q <= 8'h00;
                ok_q <= 1'b1;
                cnt_q <= CW'(swu_pkg::REPLY_WAIT_BITS * BIT_CLKS);
                state_q <= cur_q[39] ? H_GAP : H_WAIT;
                if (cur_q[39]) begin
                  cnt_q <= CW'(swu_pkg::HOST_IDLE_BITS * BIT_CLKS);
                end
              end
            end else begin
              hostOut_q <= bitIdx_q == 4'h8 ? 1'b1 : curByte[bitIdx_q[2:0]];
              bitIdx_q <= bitIdx_q + 4'h1;
            end
          end
        end
        H_GAP: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end else begin
            state_q <= H_IDLE;
          end
        end
        H_WAIT: begin
          if (lineP_q && !link.line) begin
            cnt_q <= BIT_LOAD + CW'(BIT_CLKS / 2);
            bitIdx_q <= 4'h0;
            state_q <= H_RECV;
          end else if (cnt_q == '0) begin
            rspValid_q <= 1'b1;
            rspOk_q <= 1'b0;
            state_q <= H_IDLE;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
        H_RECV: begin
          if (cnt_q != '0) begin
            cnt_q <= cnt_q - CW'(1);
          end else if (bitIdx_q < 4'h8) begin
            shift_q <= {link.line, shift_q[7:1]};
            bitIdx_q <= bitIdx_q + 4'h1;
            cnt_q <= BIT_LOAD;
          end else begin
            crc_q <= swu_pkg::crcByte(crc_q, shift_q);
            if (byteIdx_q >= 3'h3 && byteIdx_q != 3'h7) begin
              buf_q <= {buf_q[23:0], shift_q};
            end
            if (byteIdx_q == 3'h7) begin
              rspValid_q <= 1'b1;
              rspOk_q <= ok_q && byteOk;
              rspData_q <= buf_q;
              cnt_q <= CW'((swu_pkg::TAIL_BITS + swu_pkg::HOST_IDLE_BITS) *
                           BIT_CLKS);
              state_q <= H_GAP;
            end else begin
              ok_q <= ok_q && byteOk;
              byteIdx_q <= byteIdx_q + 3'h1;
              cnt_q <= CW'(swu_pkg::REPLY_WAIT_BITS * BIT_CLKS);
              state_q <= H_WAIT;
            end
          end
        end
        default: begin
          state_q <= H_IDLE;
          hostOe_q <= 1'b0;
        end
      endcase
    end
  end

  assign link.hostOut = hostOut_q;
  assign link.hostOe = hostOe_q;
  assign cmdReady = cmdReady_q;
  assign rspValid = rspValid_q;
  assign rspOk = rspOk_q;
  assign rspData = rspData_q;
endmodule

//--- test/swu_checker.sv
// concurrent checks on the shared wire between host and node ends
`timescale 1ns/1ps
module swu_checker #(
  parameter int BIT_CLKS = 160
) (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic devOut,
  input wire logic devOe,
  input wire logic hostOut,
  input wire logic hostOe,
  input wire logic line
);
  // node bit time comes from an integer divide, so allow two clocks a bit
  localparam int TOL = 172;
  int gapCnt;
  int oeCnt;
  int hiCnt;
  int hostCnt;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rstn);
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      gapCnt <= 0;
      oeCnt <= 0;
      hiCnt <= 0;
      hostCnt <= 0;
    end else begin
      gapCnt <= (hostOe || devOe) ? 0 : gapCnt + 1;
      oeCnt <= devOe ? oeCnt + 1 : 0;
      hiCnt <= (devOe && devOut) ? hiCnt + 1 : 0;
      hostCnt <= hostOe ? hostCnt + 1 : 0;
    end
  end
  one_driver_a: assert property (!(devOe && hostOe))
    else $error("both ends drive the wire");
  idle_high_a: assert property (!devOe && !hostOe |-> line)
    else $error("undriven wire not high");
  turn_gap_a: assert property ($rose(devOe) |-> gapCnt >= 7*BIT_CLKS)
    else $error("reply turnaround too short");
  reply_len_a: assert property ($fell(devOe) |->
    oeCnt >= 84*BIT_CLKS - TOL && oeCnt <= 84*BIT_CLKS + TOL)
    else $error("reply drive span wrong");
  tail_high_a: assert property ($fell(devOe) |-> hiCnt >= 5*BIT_CLKS-12)
    else $error("node released before tail ended");
  host_len_a: assert property ($fell(hostOe) |->
    (hostCnt >= 40*BIT_CLKS - 4 && hostCnt <= 40*BIT_CLKS + 4) ||
    (hostCnt >= 80*BIT_CLKS - 4 && hostCnt <= 80*BIT_CLKS + 4))
    else $error("host datagram length wrong");
  host_start_a: assert property ($rose(hostOe) |-> !hostOut)
    else $error("host drive does not open with start bit");
  start_bit_a: assert property (devOe && $fell(devOut) |-> !devOut[*8])
    else $error("node start bit too short");
  cover property ($rose(devOe));
  cover property ($fell(devOe));
  cover property ($fell(hostOe) && hostCnt > 60*BIT_CLKS);
endmodule

//--- test/test_single_wire_uart_read_reply_crc.sv
// testbench: host and node ends on one wire, plus a hand-driven wire
`timescale 1ns/1ps
module test_single_wire_uart_read_reply_crc;
  localparam int BT = 32;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic cmdValid = 1'b0;
  logic cmdWrite = 1'b0;
  logic [6:0] cmdAddr = 7'h00;
  logic [31:0] cmdData = 32'h0;
  logic [3:0] turnSetting = 4'h1;
  logic [31:0] rdData = 32'h0;
  logic bOut = 1'b1;
  logic bOe = 1'b0;
  logic cmdReady, rspValid, rspOk, rdReq, wrValid;
  logic [31:0] rspData, wrData, wrDataB, exp;
  logic [6:0] rdAddr, wrAddr;
  logic [7:0] dgCount, dgCountB;
  int mismatches = 0;
  int checked = 0;
  int n;
  int e;
  swu_link_if link();
  swu_link_if link2();
  assign link2.hostOut = bOut;
  assign link2.hostOe = bOe;
  always #25 core_clk = ~core_clk;
  swu_host #(.BIT_CLKS(BT)) i_swu_host(.core_clk(core_clk), .rstn(rstn),
    .link(link.host), .cmdValid(cmdValid), .cmdReady(cmdReady),
    .cmdWrite(cmdWrite), .cmdAddr(cmdAddr), .cmdData(cmdData),
    .rspValid(rspValid), .rspOk(rspOk), .rspData(rspData));
  swu_device i_swu_device(.core_clk(core_clk), .rstn(rstn),
    .link(link.device), .turnSetting(turnSetting), .rdData(rdData),
    .rdReq(rdReq), .rdAddr(rdAddr), .wrValid(wrValid), .wrAddr(wrAddr),
    .wrData(wrData), .dgCount(dgCount));
  swu_device i_swu_device_b(.core_clk(core_clk), .rstn(rstn),
    .link(link2.device), .turnSetting(4'h1), .rdData(32'h0), .rdReq(),
    .rdAddr(), .wrValid(), .wrAddr(), .wrData(wrDataB),
    .dgCount(dgCountB));
  swu_checker #(.BIT_CLKS(BT)) i_swu_checker(.core_clk(core_clk),
    .rstn(rstn), .devOut(link.devOut), .devOe(link.devOe),
    .hostOut(link.hostOut), .hostOe(link.hostOe), .line(link.line));
  task automatic chk(input string what, input logic [31:0] ex,
                     input logic [31:0] got);
    checked++;
    if (got !== ex) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, ex, got);
    end
  endtask
  task automatic results();
    if (mismatches == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  function automatic logic sel(input int k);
    case (k)
      0: return rspValid === 1'b1;
      1: return wrValid === 1'b1;
      2: return rdReq === 1'b1;
      default: return link.devOe === 1'b1;
    endcase
  endfunction
  task automatic waitSig(input int k, input int lim, output int cnt);
    cnt = 0;
    while (!sel(k) && cnt < lim) begin
      @(posedge core_clk);
      cnt++;
    end
    chk("handshake wait", 32'h1, {31'h0, cnt < lim});
  endtask
  task automatic cmd(input logic w, input logic [6:0] a,
                     input logic [31:0] d);
    @(negedge core_clk);
    cmdValid = 1'b1;
    cmdWrite = w;
    cmdAddr = a;
    cmdData = d;
    @(posedge core_clk);
    while (cmdReady !== 1'b1) @(posedge core_clk);
    @(negedge core_clk);
    cmdValid = 1'b0;
  endtask
  // hand-driven host: 8-bit frames, no parity, lsb first
  task automatic sendDg(input logic [7:0] addr, input logic [7:0] bad);
    logic [7:0] m [8];
    logic [7:0] c;
    logic [9:0] f;
    m = '{8'h05, addr, 8'h85, 8'hde, 8'had, 8'hbe, 8'hef, 8'h00};
    c = 8'h00;
    for (int i = 0; i < 7; i++) begin
      for (int j = 0; j < 8; j++) begin
        c = {c[6:0], 1'b0} ^ ((c[7] ^ m[i][j]) ? 8'h07 : 8'h00);
      end
    end
    m[7] = c ^ bad;
    @(negedge core_clk);
    bOe = 1'b1;
    foreach (m[i]) begin
      f = {1'b1, m[i], 1'b0};
      for (int b = 0; b < 10; b++) begin
        bOut = f[b];
        repeat (BT) @(negedge core_clk);
      end
    end
    bOe = 1'b0;
    // recovery after an error runs on lastBt_q: the reset bit time of 160 clocks until a datagram ends with a matching crc
    repeat (64*BT) @(negedge core_clk);
  endtask
  initial begin
    repeat (5) @(negedge core_clk);
    rstn = 1'b1;
    repeat (3) @(negedge core_clk);
    cmd(1'b1, 7'h2a, 32'h1234abcd);
    waitSig(1, 4000, n);
    chk("wrAddr", 32'h2a, {25'h0, wrAddr});
    chk("wrData", 32'h1234abcd, wrData);
    chk("dgCount", 32'h1, {24'h0, dgCount});
    for (int t = 0; t < 4; t++) begin
      @(negedge core_clk);
      turnSetting = 4'(t);
      exp = {4'(t), 28'h5a0c3e1};
      rdData = exp;
      cmd(1'b0, 7'h11 + 7'(t), 32'h0);
      waitSig(2, 2000, n);
      @(negedge core_clk);
      rdData = ~exp;
      waitSig(3, 40*BT, n);
      e = 8*((t == 0) ? 1 : t)*BT;
      chk("turnaround", 32'h1, {31'h0, n >= e-60 && n <= e+60});
      waitSig(0, 200*BT, n);
      chk("rspOk", 32'h1, {31'h0, rspOk});
      chk("rspData", exp, rspData);
      chk("rdAddr", 32'h11 + t, {25'h0, rdAddr});
      chk("dgCount", 32'h1, {24'h0, dgCount});
      // leave room for the node's four-bit tail before the next request
      repeat (8*BT) @(negedge core_clk);
    end
    sendDg(8'h00, 8'h01);
    chk("dgCountB", 32'h0, {24'h0, dgCountB});
    sendDg(8'h00, 8'h00);
    chk("dgCountB", 32'h1, {24'h0, dgCountB});
    chk("wrDataB", 32'hdeadbeef, wrDataB);
    sendDg(8'hff, 8'h00);
    chk("dgCountB", 32'h1, {24'h0, dgCountB});
    sendDg(8'h01, 8'h00);
    chk("dgCountB", 32'h1, {24'h0, dgCountB});
    // a short low pulse must swallow a datagram that follows too soon
    @(negedge core_clk);
    bOut = 1'b0;
    bOe = 1'b1;
    repeat (8) @(negedge core_clk);
    bOe = 1'b0;
    sendDg(8'h00, 8'h00);
    chk("dgCountB", 32'h1, {24'h0, dgCountB});
    results();
  end
  initial begin
    repeat (60000) @(posedge core_clk);
    mismatches++;
    results();
  end
endmodule
